// file: coh_device.sv
// device end: takes system coherence commands, probes caches, answers, streams blocks
//
// Summary of operation
// - system owns bus before sending commands
// - at most two unanswered commands buffered
// - bus owner drives no-op when idle
// - invalidate: second-level hit acks, miss no-acks
// - board cache: invalidate acks board, l2 still probed
// - set-shared marks block shared in both caches
// - set-shared answer: l2, board, else no-ack
// - read-modified: dirty l2 hit sends data
// - l2 miss with board cache: board read
// - read-modified-invalidate invalidates instead of sharing
// - presence bit is l2 hit or lock hit
// - least response times per cache configuration
// - l2 data starts with the response edge
// - board cache updated as chunks go out
// - board index set at response, dack advances
// - board tag written in second data chunk
// - invalidate never reads block data out
// - requested bus released at sampling edge
// - device drives bus again two edges later
// - system keeps command, address, parity valid
module coh_device
  import coh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  coh_if.device link,
  input wire logic boardCachePresent,
  input wire logic systemParityDisable,
  output logic probeReq,
  output logic [ADDR_W-1:0] probeAddr,
  input wire logic probeAck,
  input wire logic probeHitL2,
  input wire logic probeDirtyL2,
  input wire logic probeLockHit,
  input wire logic [CHUNKS*DATA_W-1:0] blockData,
  output logic [1:0] boardIndex,
  output logic l2Invalidate,
  output logic l2SetShared,
  output logic bcTagWr,
  output logic [1:0] bcTagState,
  output logic bcDataWr,
  output logic [DATA_W-1:0] bcDataOut,
  output logic parityError,
  output logic overflowError
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROBE = 2'b01,
    ST_WAIT = 2'b11,
    ST_XFER = 2'b10
  } state_e;

  // -----------------------------------------------------------------
  // bus ownership and command capture
  // -----------------------------------------------------------------
  logic reqD1_r, reqD2_r, devOe_r, devOe_nxt;
  logic cmdSeen, cmdLegal, parOk;
  logic qInValid, qInReady, qOutValid, qOutReady;
  logic [CMD_W+ADDR_W-1:0] qOutData;
  logic parityError_r, parityError_nxt, overflowError_r, overflowError_nxt;

  // three stages so our enable returns only after the system's enable has dropped
  assign devOe_nxt = !link.addrBusReq && !reqD1_r && !reqD2_r;
  assign link.devOe = devOe_r;
  assign link.cmdDev = CMD_NOP;
  assign link.addrDev = '0;
  assign link.parDev = 1'b0;

  assign cmdSeen = !devOe_r && (link.cmdBus != CMD_NOP);
  assign cmdLegal = (link.cmdBus == CMD_INVAL) || (link.cmdBus == CMD_SET_SHARED)
    || (link.cmdBus == CMD_RDMOD_SHARE) || (link.cmdBus == CMD_RDMOD_INVAL);
  assign parOk = systemParityDisable || !(^{link.cmdBus, link.addrBus, link.parBus});
  assign qInValid = cmdSeen && cmdLegal && parOk;
  assign parityError_nxt = cmdSeen && !parOk;
  // a command that finds both entries full has nowhere to go and is dropped
  assign overflowError_nxt = qInValid && !qInReady;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reqD1_r <= 1'b0;
      reqD2_r <= 1'b0;
      devOe_r <= 1'b1;
      parityError_r <= 1'b0;
      overflowError_r <= 1'b0;
    end else if (ce) begin
      reqD1_r <= link.addrBusReq;
      reqD2_r <= reqD1_r;
      devOe_r <= devOe_nxt;
      parityError_r <= parityError_nxt;
      overflowError_r <= overflowError_nxt;
    end
  end

  assign parityError = parityError_r;
  assign overflowError = overflowError_r;

  // in-order command queue, two deep
  two_entry_buffer #(.W(CMD_W + ADDR_W)) cmdQueue (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .inValid(qInValid),
    .inData({link.cmdBus, link.addrBus}),
    .inReady(qInReady),
    .outValid(qOutValid),
    .outData(qOutData),
    .outReady(qOutReady)
  );

  // -----------------------------------------------------------------
  // command processing
  // -----------------------------------------------------------------
  state_e state_r, state_nxt;
  logic [CMD_W-1:0] cmd_r, cmd_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic hit_r, hit_nxt, dirty_r, dirty_nxt, lock_r, lock_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic fromBc_r, fromBc_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic probeReq_r, probeReq_nxt;
  logic [2:0] res_r, res_nxt;
  logic resValid_r, resValid_nxt, dataValid_r, dataValid_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic l2Inv_r, l2Inv_nxt, l2Shr_r, l2Shr_nxt;
  logic tagWr_r, tagWr_nxt, bcWr_r, bcWr_nxt;
  logic [1:0] tagSt_r, tagSt_nxt;
  logic isRead, l2Serve;
  logic [1:0] code;
  logic [3:0] minCyc;
  logic [1:0] holdTag;

  always_comb begin
    isRead = (cmd_r == CMD_RDMOD_SHARE) || (cmd_r == CMD_RDMOD_INVAL);
    // reads need dirty data in l2; invalidate with a board cache skips l2
    l2Serve = isRead ? (hit_r && dirty_r) : hit_r;
    if (cmd_r == CMD_INVAL && boardCachePresent) begin
      code = RES_ACK_BC;
    end else if (l2Serve) begin
      code = RES_ACK_L2;
    end else if (boardCachePresent) begin
      code = RES_ACK_BC;
    end else begin
      code = RES_NO_ACK;
    end
    if (boardCachePresent) begin
      minCyc = MIN_BC_CYC;
    end else if (code == RES_ACK_L2) begin
      minCyc = MIN_ACKL2_CYC;
    end else begin
      minCyc = MIN_NO_ACK_RESPONSE_CYC;
    end
    // read-modified-invalidate drops the block, read-modified-share keeps it shared dirty
    holdTag = (cmd_r == CMD_RDMOD_INVAL) ? TAG_INVALID : TAG_SHARED_DIRTY;
  end

  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    hit_nxt = hit_r;
    dirty_nxt = dirty_r;
    lock_nxt = lock_r;
    cnt_nxt = cnt_r;
    fromBc_nxt = fromBc_r;
    idx_nxt = idx_r;
    probeReq_nxt = 1'b0;
    res_nxt = res_r;
    resValid_nxt = 1'b0;
    dataValid_nxt = dataValid_r;
    data_nxt = data_r;
    l2Inv_nxt = 1'b0;
    l2Shr_nxt = 1'b0;
    tagWr_nxt = 1'b0;
    tagSt_nxt = tagSt_r;
    bcWr_nxt = 1'b0;
    qOutReady = 1'b0;
    if (cnt_r != 4'hf) begin
      cnt_nxt = cnt_r + 4'h1;
    end
    case (state_r)
      ST_IDLE: begin
        qOutReady = 1'b1;
        if (qOutValid) begin
          {cmd_nxt, addr_nxt} = qOutData;
          probeReq_nxt = 1'b1;
          cnt_nxt = 4'h1;
          state_nxt = ST_PROBE;
        end
      end
      ST_PROBE: begin
        if (probeAck) begin
          hit_nxt = probeHitL2;
          dirty_nxt = probeDirtyL2;
          lock_nxt = probeLockHit;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_r >= minCyc) begin
          res_nxt = {hit_r || lock_r, code};
          resValid_nxt = 1'b1;
          state_nxt = ST_IDLE;
          if (cmd_r == CMD_INVAL) begin
            // only state changes here, the block is never sent
            l2Inv_nxt = hit_r;
            tagWr_nxt = boardCachePresent;
            tagSt_nxt = TAG_INVALID;
          end else if (cmd_r == CMD_SET_SHARED) begin
            l2Shr_nxt = hit_r;
            tagWr_nxt = boardCachePresent;
            tagSt_nxt = TAG_SHARED_DIRTY;
          end else if (code != RES_NO_ACK) begin
            l2Shr_nxt = hit_r && (cmd_r == CMD_RDMOD_SHARE);
            l2Inv_nxt = hit_r && (cmd_r == CMD_RDMOD_INVAL);
            fromBc_nxt = (code == RES_ACK_BC);
            idx_nxt = 2'h0;
            data_nxt = blockData[DATA_W-1:0];
            dataValid_nxt = 1'b1;
            bcWr_nxt = boardCachePresent && (code == RES_ACK_L2);
            state_nxt = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        if (link.dack) begin
          if (idx_r == 2'(CHUNKS - 1)) begin
            dataValid_nxt = 1'b0;
            state_nxt = ST_IDLE;
          end else begin
            idx_nxt = idx_r + 2'h1;
            data_nxt = blockData[(32'(idx_nxt) * DATA_W) +: DATA_W];
            // write pulse pairs with the chunk and index now on the bus
            bcWr_nxt = boardCachePresent && !fromBc_r;
            if (idx_r == 2'h0 && boardCachePresent) begin
              tagWr_nxt = 1'b1;
              tagSt_nxt = holdTag;
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cmd_r <= CMD_NOP;
      addr_r <= '0;
      hit_r <= 1'b0;
      dirty_r <= 1'b0;
      lock_r <= 1'b0;
      cnt_r <= 4'h0;
      fromBc_r <= 1'b0;
      idx_r <= 2'h0;
      probeReq_r <= 1'b0;
      res_r <= 3'h0;
      resValid_r <= 1'b0;
      dataValid_r <= 1'b0;
      data_r <= '0;
      l2Inv_r <= 1'b0;
      l2Shr_r <= 1'b0;
      tagWr_r <= 1'b0;
      tagSt_r <= TAG_INVALID;
      bcWr_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      hit_r <= hit_nxt;
      dirty_r <= dirty_nxt;
      lock_r <= lock_nxt;
      cnt_r <= cnt_nxt;
      fromBc_r <= fromBc_nxt;
      idx_r <= idx_nxt;
      probeReq_r <= probeReq_nxt;
      res_r <= res_nxt;
      resValid_r <= resValid_nxt;
      dataValid_r <= dataValid_nxt;
      data_r <= data_nxt;
      l2Inv_r <= l2Inv_nxt;
      l2Shr_r <= l2Shr_nxt;
      tagWr_r <= tagWr_nxt;
      tagSt_r <= tagSt_nxt;
      bcWr_r <= bcWr_nxt;
    end
  end

  assign link.addrRes = res_r;
  assign link.resValid = resValid_r;
  assign link.dataBus = data_r;
  assign link.dataValid = dataValid_r;
  assign probeReq = probeReq_r;
  assign probeAddr = addr_r;
  assign boardIndex = idx_r;
  assign l2Invalidate = l2Inv_r;
  assign l2SetShared = l2Shr_r;
  assign bcTagWr = tagWr_r;
  assign bcTagState = tagSt_r;
  assign bcDataWr = bcWr_r;
  assign bcDataOut = data_r;
endmodule : coh_device

// file: coh_if.sv
// command/address bus, response and data lines between device and system
interface coh_if;
  import coh_pkg::*;
  logic [CMD_W-1:0] cmdDev;
  logic [ADDR_W-1:0] addrDev;
  logic parDev;
  logic devOe;
  logic [CMD_W-1:0] cmdSys;
  logic [ADDR_W-1:0] addrSys;
  logic parSys;
  logic sysOe;
  logic [CMD_W-1:0] cmdBus;
  logic [ADDR_W-1:0] addrBus;
  logic parBus;
  logic addrBusReq;
  logic [2:0] addrRes;
  logic resValid;
  logic [DATA_W-1:0] dataBus;
  logic dataValid;
  logic dack;

  // wire level from the two enables; an undriven bus reads as no-op
  assign cmdBus = sysOe ? cmdSys : (devOe ? cmdDev : CMD_NOP);
  assign addrBus = sysOe ? addrSys : (devOe ? addrDev : '0);
  assign parBus = sysOe ? parSys : (devOe ? parDev : 1'b0);

  modport device (
    output cmdDev, addrDev, parDev, devOe, addrRes, resValid, dataBus, dataValid,
    input cmdBus, addrBus, parBus, addrBusReq, dack
  );
  modport system (
    output cmdSys, addrSys, parSys, sysOe, addrBusReq, dack,
    input cmdBus, addrBus, parBus, addrRes, resValid, dataBus, dataValid
  );
endinterface : coh_if

// file: coh_link_assertions.sv
// concurrent checks on the command link between the device and system ends
module coh_link_assertions
  import coh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [CMD_W-1:0] cmdBus,
  input wire logic [ADDR_W-1:0] addrBus,
  input wire logic parBus,
  input wire logic devOe,
  input wire logic sysOe,
  input wire logic addrBusReq,
  input wire logic [2:0] addrRes,
  input wire logic resValid,
  input wire logic dataValid,
  input wire logic dack
);
  // ----------------------------------------------------------------
  // clocking and sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence cmd_sent;
    sysOe && (cmdBus != CMD_NOP);
  endsequence

  // two dead cycles while the system drivers turn off
  sequence bus_back;
    !devOe [*2] ##1 devOe;
  endsequence

  // ----------------------------------------------------------------
  // bus ownership
  // ----------------------------------------------------------------
  a_one_bus_driver: assert property (!(devOe && sysOe))
    else $error("both ends drive the command bus");
  a_release_on_req: assert property (addrBusReq |=> !devOe)
    else $error("device kept the bus after a request");
  a_return_two_edges: assert property ($fell(addrBusReq) |=> bus_back)
    else $error("device did not retake the bus two edges later");
  a_sys_owns_first: assert property (sysOe |-> addrBusReq)
    else $error("system drove the bus without a request");
  a_owner_idles_noop: assert property (devOe |-> cmdBus == CMD_NOP)
    else $error("device owner drove a command other than no-op");
  a_parity_valid: assert property (sysOe |-> parBus == ^{cmdBus, addrBus})
    else $error("command and address parity wrong");

  // ----------------------------------------------------------------
  // answers and data
  // ----------------------------------------------------------------
  a_min_latency: assert property (cmd_sent |=> !resValid [*2])
    else $error("answer came too early");
  a_answer_bounded: assert property (cmd_sent |-> ##[1:80] resValid)
    else $error("command was never answered");
  a_answer_legal: assert property (resValid |-> addrRes[1:0] != 2'h3)
    else $error("illegal answer code");
  a_data_at_answer: assert property ($rose(dataValid) |-> resValid
    && addrRes[1:0] != RES_NO_ACK)
    else $error("block data did not start with the answer");
  a_dack_in_block: assert property (dack |-> dataValid)
    else $error("chunk acknowledge outside a block transfer");
endmodule : coh_link_assertions

// file: coh_pkg.sv
// shared constants for the coherence command link
package coh_pkg;
  localparam int CMD_W = 4;
  localparam int ADDR_W = 36;
  localparam int DATA_W = 128;
  localparam int CHUNKS = 4;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_INVAL = 4'h2;
  localparam logic [3:0] CMD_SET_SHARED = 4'h3;
  localparam logic [3:0] CMD_RDMOD_SHARE = 4'h5;
  localparam logic [3:0] CMD_RDMOD_INVAL = 4'h7;
  localparam logic [1:0] RES_NO_ACK = 2'h0;
  localparam logic [1:0] RES_ACK_L2 = 2'h1;
  localparam logic [1:0] RES_ACK_BC = 2'h2;
  localparam logic [1:0] TAG_INVALID = 2'h0;
  localparam logic [1:0] TAG_SHARED_DIRTY = 2'h3;
  // processor period is a plain default, the system clock is 100 MHz
  localparam int SYS_PERIOD_PS = 10000;
  localparam int CPU_PERIOD_PS = 2000;
  localparam int NO_ACK_RESPONSE_NOBC_CPU = 8;
  localparam int ACKL2_NOBC_CPU = 12;
  localparam int ANY_BC_CPU = 10;
  localparam logic [3:0] MIN_NO_ACK_RESPONSE_CYC =
    4'((NO_ACK_RESPONSE_NOBC_CPU * CPU_PERIOD_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [3:0] MIN_ACKL2_CYC =
    4'((ACKL2_NOBC_CPU * CPU_PERIOD_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [3:0] MIN_BC_CYC =
    4'((ANY_BC_CPU * CPU_PERIOD_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [1:0] MAX_OUTSTANDING = 2'h2;
endpackage : coh_pkg

// file: coh_system.sv
// system end: wins the bus, sends one command, collects responses and block data
module coh_system
  import coh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  coh_if.system link,
  input wire logic reqValid,
  input wire logic [CMD_W-1:0] reqCmd,
  input wire logic [ADDR_W-1:0] reqAddr,
  output logic reqReady,
  output logic respValid,
  output logic [1:0] respCode,
  output logic respPresent,
  output logic chunkValid,
  output logic [DATA_W-1:0] chunkData,
  input wire logic chunkReady
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_GRANT = 3'b011,
    ST_DRIVE = 3'b010,
    ST_HOLD = 3'b110
  } state_e;

  state_e state_r, state_nxt;
  logic req_r, req_nxt, oe_r, oe_nxt;
  logic [CMD_W-1:0] cmd_r, cmd_nxt, cmdOut_r, cmdOut_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [1:0] outst_r, outst_nxt;
  logic ready_r, ready_nxt, dack_r, dack_nxt;
  logic respValid_r, chunkValid_r;
  logic [2:0] res_r;
  logic [DATA_W-1:0] chunk_r;

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    oe_nxt = oe_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    cmdOut_nxt = cmdOut_r;
    outst_nxt = outst_r;
    if (link.resValid) begin
      outst_nxt = outst_nxt - 2'h1;
    end
    case (state_r)
      ST_IDLE: begin
        if (reqValid && ready_r) begin
          cmd_nxt = reqCmd;
          addr_nxt = reqAddr;
          req_nxt = 1'b1;
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        state_nxt = ST_GRANT; // device releases at this edge
      end
      ST_GRANT: begin
        oe_nxt = 1'b1;
        cmdOut_nxt = cmd_r;
        outst_nxt = outst_nxt + 2'h1;
        state_nxt = ST_DRIVE;
      end
      ST_DRIVE: begin
        cmdOut_nxt = CMD_NOP;
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        oe_nxt = 1'b0;
        req_nxt = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // never a third unanswered command
    ready_nxt = (state_nxt == ST_IDLE) && !(reqValid && ready_r) && (outst_nxt < MAX_OUTSTANDING);
    // one pulse per chunk; the device shows the next chunk an edge later
    dack_nxt = link.dataValid && chunkReady && !dack_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      req_r <= 1'b0;
      oe_r <= 1'b0;
      cmd_r <= CMD_NOP;
      addr_r <= '0;
      cmdOut_r <= CMD_NOP;
      outst_r <= 2'h0;
      ready_r <= 1'b0;
      dack_r <= 1'b0;
      respValid_r <= 1'b0;
      res_r <= 3'h0;
      chunkValid_r <= 1'b0;
      chunk_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      oe_r <= oe_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      cmdOut_r <= cmdOut_nxt;
      outst_r <= outst_nxt;
      ready_r <= ready_nxt;
      dack_r <= dack_nxt;
      respValid_r <= link.resValid;
      res_r <= link.resValid ? link.addrRes : res_r;
      chunkValid_r <= dack_nxt;
      chunk_r <= dack_nxt ? link.dataBus : chunk_r;
    end
  end

  assign link.addrBusReq = req_r;
  assign link.sysOe = oe_r;
  assign link.cmdSys = cmdOut_r;
  assign link.addrSys = addr_r;
  assign link.parSys = ^{cmdOut_r, addr_r};
  assign link.dack = dack_r;
  assign reqReady = ready_r;
  assign respValid = respValid_r;
  assign respCode = res_r[1:0];
  assign respPresent = res_r[2];
  assign chunkValid = chunkValid_r;
  assign chunkData = chunk_r;
endmodule : coh_system

// file: tb_top.sv
// testbench: both link ends face each other, a queue model checks every answer
module tb_top;
  import coh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_b, probeAck, hitL2, dirtyL2, lockHit, bcPresent;
  logic reqValid, reqReady, respValid, respPresent, chunkValid, chunkReady;
  logic [CMD_W-1:0] reqCmd;
  logic [ADDR_W-1:0] reqAddr;
  logic [1:0] respCode;
  logic [DATA_W-1:0] chunkData;
  logic [CHUNKS*DATA_W-1:0] blockData;
  logic [DATA_W-1:0] expChunk[$];
  logic [2:0] expResp[$];
  int num_errors = 0;
  int checks = 0;
  logic probeReq, l2Inv, l2Shr, tagWr, bcWr, parErr, ovfErr;
  logic [ADDR_W-1:0] probeAddr;
  logic [1:0] boardIndex, tagSt, expTag;
  logic [DATA_W-1:0] bcDataOut;
  int nInv, nShr, nTag, nBcWr;

  coh_if coh_if_inst ();

  coh_device coh_device_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1), .link(coh_if_inst.device),
    .boardCachePresent(bcPresent), .systemParityDisable(1'b0), .probeReq(probeReq),
    .probeAddr(probeAddr), .probeAck(probeAck), .probeHitL2(hitL2), .probeDirtyL2(dirtyL2),
    .probeLockHit(lockHit), .blockData(blockData), .boardIndex(boardIndex),
    .l2Invalidate(l2Inv), .l2SetShared(l2Shr), .bcTagWr(tagWr), .bcTagState(tagSt),
    .bcDataWr(bcWr), .bcDataOut(bcDataOut), .parityError(parErr), .overflowError(ovfErr));

  coh_system coh_system_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1), .link(coh_if_inst.system),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqAddr(reqAddr), .reqReady(reqReady),
    .respValid(respValid), .respCode(respCode), .respPresent(respPresent),
    .chunkValid(chunkValid), .chunkData(chunkData), .chunkReady(chunkReady));

  coh_link_assertions coh_link_assertions_inst (.clk(clk), .rst_b(rst_b),
    .cmdBus(coh_if_inst.cmdBus), .addrBus(coh_if_inst.addrBus), .parBus(coh_if_inst.parBus),
    .devOe(coh_if_inst.devOe), .sysOe(coh_if_inst.sysOe),
    .addrBusReq(coh_if_inst.addrBusReq), .addrRes(coh_if_inst.addrRes),
    .resValid(coh_if_inst.resValid), .dataValid(coh_if_inst.dataValid),
    .dack(coh_if_inst.dack));

  // ----------------------------------------------------------------
  // clock, stalls and checks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic compare(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  // slow probes and receiver stalls; one command at a time keeps the two-entry buffer at most one deep
  always @(posedge clk) begin
    #1;
    probeAck = ($urandom % 3) != 0;
    chunkReady = ($urandom % 4) != 0;
    if (respValid === 1'b1) begin
      if (expResp.size() == 0) begin
        compare(DATA_W'(1), DATA_W'(0));
      end else begin
        compare(DATA_W'(respCode), DATA_W'(expResp[0][1:0]));
        compare(DATA_W'(respPresent), DATA_W'(expResp[0][2]));
        void'(expResp.pop_front());
      end
    end
    if (chunkValid === 1'b1) begin
      if (expChunk.size() == 0) begin
        compare(DATA_W'(1), DATA_W'(0));
      end else begin
        compare(chunkData, expChunk.pop_front());
      end
    end
    if (probeReq === 1'b1) begin
      compare(DATA_W'(probeAddr), DATA_W'(reqAddr));
    end
    if (parErr === 1'b1 || ovfErr === 1'b1) begin
      compare(DATA_W'(1), DATA_W'(0));
    end
    nInv += int'(l2Inv === 1'b1);
    nShr += int'(l2Shr === 1'b1);
    if (tagWr === 1'b1) begin
      nTag++;
      compare(DATA_W'(tagSt), DATA_W'(expTag));
      if (reqCmd == CMD_RDMOD_SHARE || reqCmd == CMD_RDMOD_INVAL) begin
        compare(DATA_W'(boardIndex), DATA_W'(1));
      end
    end
    if (bcWr === 1'b1) begin
      nBcWr++;
      compare(bcDataOut, blockData[DATA_W*boardIndex+:DATA_W]);
    end
  end

  // ----------------------------------------------------------------
  // model and stimulus
  // ----------------------------------------------------------------
  task automatic run_cmd(input int n, input logic [3:0] cmd);
    int code;
    int w;
    int eInv, eShr, eBcWr;
    logic rd;
    @(posedge clk);
    #1;
    nInv = 0;
    nShr = 0;
    nTag = 0;
    nBcWr = 0;
    bcPresent = n[2];
    {hitL2, dirtyL2, lockHit} = 3'($urandom);
    for (int k = 0; k < CHUNKS * DATA_W / 32; k++) begin
      blockData[32*k+:32] = $urandom;
    end
    if (cmd == CMD_INVAL) begin
      code = bcPresent ? 2 : (hitL2 ? 1 : 0);
    end else if (cmd == CMD_SET_SHARED) begin
      code = hitL2 ? 1 : (bcPresent ? 2 : 0);
    end else begin
      code = (hitL2 && dirtyL2) ? 1 : (bcPresent ? 2 : 0);
    end
    expResp.push_back({hitL2 | lockHit, 2'(code)});
    rd = (cmd == CMD_RDMOD_SHARE) || (cmd == CMD_RDMOD_INVAL);
    eInv = int'(hitL2 && (cmd == CMD_INVAL || (cmd == CMD_RDMOD_INVAL && code != 0)));
    eShr = int'(hitL2 && (cmd == CMD_SET_SHARED || (cmd == CMD_RDMOD_SHARE && code != 0)));
    eBcWr = (rd && code == 1 && bcPresent) ? CHUNKS : 0;
    expTag = (cmd == CMD_INVAL || cmd == CMD_RDMOD_INVAL) ? TAG_INVALID : TAG_SHARED_DIRTY;
    if (code != 0 && cmd != CMD_INVAL && cmd != CMD_SET_SHARED) begin
      for (int k = 0; k < CHUNKS; k++) begin
        expChunk.push_back(blockData[DATA_W*k+:DATA_W]);
      end
    end
    reqCmd = cmd;
    reqAddr = {$urandom, 4'h0};
    reqValid = 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (reqReady !== 1'b1 && w < 200);
    if (w >= 200) begin
      compare(DATA_W'(reqReady), DATA_W'(1));
    end
    #1;
    reqValid = 1'b0;
    w = 0;
    while ((expResp.size() != 0 || expChunk.size() != 0) && w < 400) begin
      @(posedge clk);
      w++;
    end
    if (w >= 400) begin
      compare(DATA_W'(expResp.size() + expChunk.size()), DATA_W'(0));
    end
    // let the last state pulses land before counting them
    repeat (3) @(posedge clk);
    compare(DATA_W'(nInv), DATA_W'(eInv));
    compare(DATA_W'(nShr), DATA_W'(eShr));
    compare(DATA_W'(nTag), DATA_W'(bcPresent));
    compare(DATA_W'(nBcWr), DATA_W'(eBcWr));
    $display("test %0d cmd %h board %0d done", n, cmd, bcPresent);
  endtask : run_cmd

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    logic [3:0] cmds[4];
    cmds = '{CMD_INVAL, CMD_SET_SHARED, CMD_RDMOD_SHARE, CMD_RDMOD_INVAL};
    rst_b = 1'b0;
    probeAck = 1'b0;
    chunkReady = 1'b0;
    {hitL2, dirtyL2, lockHit, bcPresent} = 4'h0;
    reqValid = 1'b0;
    reqCmd = CMD_NOP;
    reqAddr = '0;
    blockData = '0;
    void'($urandom(42419));
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // every code with and without a board cache, random hit, dirty and lock
    for (int n = 0; n < 48; n++) begin
      run_cmd(n, cmds[n % 4]);
    end
    print_verdict();
  end

  // each command needs well under 400 cycles
  initial begin
    #(48 * 400 * 10);
    num_errors++;
    print_verdict();
  end
endmodule : tb_top

// file: two_entry_buffer.sv
// two-entry buffer with valid and ready on both sides
module two_entry_buffer #(
  parameter int W = 40
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [1:0] count_r, count_nxt;
  logic push, pop;

  assign inReady = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outData = mem_r[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    mem_nxt = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt = ~wrPtr_r;
    end
    if (pop) begin
      rdPtr_nxt = ~rdPtr_r;
    end
    if (push && !pop) begin
      count_nxt = count_r + 2'h1;
    end else if (pop && !push) begin
      count_nxt = count_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else if (ce) begin
      mem_r <= mem_nxt;
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule : two_entry_buffer
